// ---- include/mcr_pkg.sv ----
// ====================================================================
// shared constants and types for the change detector control block
// ====================================================================
package mcr_pkg;

    // ================================================================
    // register map and widths
    // ================================================================
    localparam logic [7:0]  MCR_CONFIG_B_ADDR  = 8'h30;  // change_detect_config_b
    localparam logic [7:0]  MCR_CONFIG_B_RESET = 8'h00;  // all fields off after reset
    localparam int          MCR_DATA_W         = 12;     // trimmed sample width
    localparam int          MCR_CNT_W          = 8;      // debounce counter width
    localparam int          MCR_AXES           = 3;      // x, y, z
    localparam logic [2:0]  MCR_MAG_CHANNELS   = 3'h1;   // magnitude uses the x channel only

    // ================================================================
    // field positions inside change_detect_config_b
    // ================================================================
    localparam int MCR_ENABLE_BIT   = 7;  // change_detect_enable
    localparam int MCR_REFMODE_LSB  = 5;  // reference_update_mode[1:0]
    localparam int MCR_OT_DBM_BIT   = 4;  // outside_debounce_mode
    localparam int MCR_WT_DBM_BIT   = 3;  // inside_debounce_mode
    localparam int MCR_WT_SEL_BIT   = 2;  // inside_axis_combine_select
    localparam int MCR_MAG_BIT      = 1;  // input mode: vector magnitude
    localparam int MCR_REFRESH_BIT  = 0;  // reference_refresh_request

    // ================================================================
    // types
    // ================================================================
    typedef enum logic [1:0] {
        MCR_REF_FIRST_OT = 2'b00,  // first sample, then recapture on outside event
        MCR_REF_HOLD     = 2'b01,  // first sample, then hold
        MCR_REF_SLOPE    = 2'b10,  // previous sample every evaluation
        MCR_REF_ZERO     = 2'b11   // absolute mode
    } mcr_ref_mode_t;

    // packed so that the struct lines up with the register byte
    typedef struct packed {
        logic          change_detect_enable;
        mcr_ref_mode_t reference_update_mode;
        logic          outside_debounce_mode;
        logic          inside_debounce_mode;
        logic          inside_axis_combine_select;
        logic          magnitude_mode;
        logic          reference_refresh_request;
    } mcr_config_t;

    typedef logic signed [MCR_DATA_W-1:0]         mcr_data_t;
    typedef logic [MCR_AXES-1:0][MCR_DATA_W-1:0]  mcr_triplet_t;

    // one decimated sample per output-data-rate period
    typedef struct packed {
        logic         valid;
        mcr_triplet_t axes;       // [0]=x [1]=y [2]=z
        mcr_data_t    magnitude;
    } mcr_sample_t;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcr_reg_req_t;

endpackage

// ---- src/mcr_ref_store.sv ----
`timescale 1ns/10ps
// ====================================================================
// per-axis reference storage, read data straight from the cells
// ====================================================================
module mcr_ref_store (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic [2:0]           wr_en,
    input  wire mcr_pkg::mcr_triplet_t wr_data,
    output mcr_pkg::mcr_triplet_t     rd_data
);

    mcr_pkg::mcr_triplet_t ref_reg;
    mcr_pkg::mcr_triplet_t ref_next;

    // ================================================================
    // one entry per axis
    // ================================================================
    genvar gi;
    generate
        for (gi = 0; gi < mcr_pkg::MCR_AXES; gi++) begin : g_entry
            always_comb begin
                ref_next[gi] = wr_en[gi] ? wr_data[gi] : ref_reg[gi];
            end
        end
    endgenerate

    // cells are frozen while the clock enable is low
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_reg <= '0;
        end else if (ce) begin
            ref_reg <= ref_next;
        end
    end

    assign rd_data = ref_reg;

endmodule

// ---- src/mcr_change_ctrl.sv ----
`timescale 1ns/10ps
// Function
// - mode 00: first sample, recapture on outside event
// - mode 01: first sample, hold until re-enable/refresh
// - mode 10: reference becomes previous sample
// - mode 11: references fixed at zero
// - outside debounce mode 0 decrements when false
// - outside debounce mode 1 clears when false
// - inside debounce mode 0 decrements when false
// - inside debounce mode 1 clears when false
// - inside combine: AND when 0, OR when 1
// - input mode 1 uses magnitude on x only
// - refresh request reloads references next sample while enabled
// - refresh in mode 11 keeps references zero
// - refresh request bit self-clears after reload
// - refresh request accepted in any mode
// - enabling initialises references; disabling stops detector
// - counters step once per sample period
module mcr_change_ctrl (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire mcr_pkg::mcr_reg_req_t reg_req,
    output logic [7:0]                 reg_rdata,
    input  wire mcr_pkg::mcr_sample_t  sample,
    input  wire mcr_pkg::mcr_data_t    upper_threshold,
    input  wire mcr_pkg::mcr_data_t    lower_threshold,
    input  wire logic [2:0]            outside_axis_enable,
    input  wire logic [2:0]            inside_axis_enable,
    input  wire logic [7:0]            outside_debounce_threshold,
    input  wire logic [7:0]            inside_debounce_threshold,
    output logic                       outside_event_flag,
    output logic                       inside_event_flag,
    output mcr_pkg::mcr_triplet_t      reference
);

    // ================================================================
    // debounce step shared by both counters
    // ================================================================
    // returns {flag, count}; the count saturates at the threshold so the
    // release time in decrement mode is exactly threshold plus one periods
    function automatic logic [8:0] mcr_debounce(
        input logic       cond,
        input logic [7:0] cnt,
        input logic       flag,
        input logic [7:0] thr,
        input logic       clr_mode
    );
        logic [7:0] c;
        logic       f;
        c = cnt;
        f = flag;
        if (cond) begin
            if (c < thr) begin
                c = c + 8'h01;
            end
            if (c >= thr) begin
                f = 1'b1;
            end
        end else if (clr_mode) begin
            c = 8'h00;
            f = 1'b0;
        end else if (c == 8'h00) begin
            f = 1'b0;
        end else begin
            c = c - 8'h01;
        end
        return {f, c};
    endfunction

    // ================================================================
    // state
    // ================================================================
    mcr_pkg::mcr_config_t  cfg_reg;
    mcr_pkg::mcr_config_t  cfg_next;
    logic                  refresh_pend_reg;
    logic                  refresh_pend_next;
    logic                  first_pend_reg;
    logic                  first_pend_next;
    logic [7:0]            rdata_reg;
    logic [7:0]            rdata_next;
    logic [7:0]            ot_cnt_reg;
    logic [7:0]            ot_cnt_next;
    logic [7:0]            wt_cnt_reg;
    logic [7:0]            wt_cnt_next;
    logic                  ot_flag_reg;
    logic                  ot_flag_next;
    logic                  wt_flag_reg;
    logic                  wt_flag_next;
    logic [2:0]            ref_wr;
    mcr_pkg::mcr_triplet_t ref_wdata;
    mcr_pkg::mcr_triplet_t ref_stored;
    mcr_pkg::mcr_triplet_t cur_data;
    mcr_pkg::mcr_triplet_t eff_ref;
    logic [2:0]            ot_hit;
    logic [2:0]            wt_hit;
    logic [2:0]            ot_mask;
    logic [2:0]            wt_mask;
    logic                  ot_cond;
    logic                  wt_cond;
    logic                  eval;
    logic                  cfg_write;
    logic [8:0]            ot_step;
    logic [8:0]            wt_step;

    assign eval      = sample.valid && cfg_reg.change_detect_enable;
    assign cfg_write = reg_req.wr_en && (reg_req.addr == mcr_pkg::MCR_CONFIG_B_ADDR);

    // ================================================================
    // register port
    // ================================================================
    // a refresh request waits for the next sample; a fresh write of 1 in the
    // cycle that retires the old one is kept; a sample while disabled retires a request without a reload
    always_comb begin
        cfg_next          = cfg_reg;
        refresh_pend_next = refresh_pend_reg;
        first_pend_next   = first_pend_reg;
        rdata_next        = rdata_reg;
        if (sample.valid && refresh_pend_reg) begin
            refresh_pend_next = 1'b0;
        end
        if (eval) begin
            first_pend_next = 1'b0;
        end
        if (cfg_write) begin
            cfg_next = mcr_pkg::mcr_config_t'(reg_req.wdata);
            cfg_next.reference_refresh_request = 1'b0;
            if (reg_req.wdata[mcr_pkg::MCR_REFRESH_BIT]) begin
                refresh_pend_next = 1'b1;
            end
            if (reg_req.wdata[mcr_pkg::MCR_ENABLE_BIT] && !cfg_reg.change_detect_enable) begin
                first_pend_next = 1'b1;
            end
        end
        if (reg_req.rd_en) begin
            if (reg_req.addr == mcr_pkg::MCR_CONFIG_B_ADDR) begin
                rdata_next = {cfg_reg[7:1], refresh_pend_reg};
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_reg          <= mcr_pkg::mcr_config_t'(mcr_pkg::MCR_CONFIG_B_RESET);
            refresh_pend_reg <= 1'b0;
            first_pend_reg   <= 1'b0;
            rdata_reg        <= 8'h00;
        end else if (ce) begin
            cfg_reg          <= cfg_next;
            refresh_pend_reg <= refresh_pend_next;
            first_pend_reg   <= first_pend_next;
            rdata_reg        <= rdata_next;
        end
    end

    // ================================================================
    // window comparison per channel
    // ================================================================
    // magnitude replaces x and the other channels drop out of both masks
    always_comb begin
        cur_data    = sample.axes;
        ot_mask     = outside_axis_enable;
        wt_mask     = inside_axis_enable;
        if (cfg_reg.magnitude_mode) begin
            cur_data[0] = sample.magnitude;
            ot_mask     = outside_axis_enable & mcr_pkg::MCR_MAG_CHANNELS;
            wt_mask     = inside_axis_enable & mcr_pkg::MCR_MAG_CHANNELS;
        end
        if (cfg_reg.reference_update_mode == mcr_pkg::MCR_REF_ZERO) begin
            eff_ref = '0;
        end else begin
            eff_ref = ref_stored;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < mcr_pkg::MCR_AXES; gi++) begin : g_axis
            logic signed [12:0] delta;
            logic signed [12:0] up_ext;
            logic signed [12:0] lo_ext;
            // one extra bit so the difference cannot wrap
            assign delta  = 13'($signed(cur_data[gi])) - 13'($signed(eff_ref[gi]));
            assign up_ext = 13'(upper_threshold);
            assign lo_ext = 13'(lower_threshold);
            assign ot_hit[gi] = (delta > up_ext) || (delta < lo_ext);
            assign wt_hit[gi] = (delta <= up_ext) && (delta >= lo_ext);
        end
    endgenerate

    // outside is any enabled axis; inside follows the combine select
    always_comb begin
        ot_cond = |(ot_hit & ot_mask);
        if (cfg_reg.inside_axis_combine_select) begin
            wt_cond = |(wt_hit & wt_mask);
        end else begin
            wt_cond = (wt_mask != 3'h0) && (&(wt_hit | ~wt_mask));
        end
    end

    // ================================================================
    // debounce counters and event flags
    // ================================================================
    always_comb begin
        ot_step      = mcr_debounce(ot_cond, ot_cnt_reg, ot_flag_reg, outside_debounce_threshold,
                                    cfg_reg.outside_debounce_mode);
        wt_step      = mcr_debounce(wt_cond, wt_cnt_reg, wt_flag_reg, inside_debounce_threshold,
                                    cfg_reg.inside_debounce_mode);
        ot_cnt_next  = ot_cnt_reg;
        ot_flag_next = ot_flag_reg;
        wt_cnt_next  = wt_cnt_reg;
        wt_flag_next = wt_flag_reg;
        if (!cfg_reg.change_detect_enable) begin
            // a disabled detector holds no count or flag over to the next enable
            ot_cnt_next  = 8'h00;
            ot_flag_next = 1'b0;
            wt_cnt_next  = 8'h00;
            wt_flag_next = 1'b0;
        end else if (eval) begin
            ot_cnt_next  = ot_step[7:0];
            ot_flag_next = ot_step[8];
            wt_cnt_next  = wt_step[7:0];
            wt_flag_next = wt_step[8];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ot_cnt_reg  <= 8'h00;
            ot_flag_reg <= 1'b0;
            wt_cnt_reg  <= 8'h00;
            wt_flag_reg <= 1'b0;
        end else if (ce) begin
            ot_cnt_reg  <= ot_cnt_next;
            ot_flag_reg <= ot_flag_next;
            wt_cnt_reg  <= wt_cnt_next;
            wt_flag_reg <= wt_flag_next;
        end
    end

    // ================================================================
    // reference update, applied after the evaluation of the same sample
    // ================================================================
    // the comparison above used the old references; the new ones land on
    // the same edge as the counters, so in mode 10 sample n is against n-1, except the first sample after enabling
    always_comb begin
        ref_wr    = 3'h0;
        ref_wdata = cur_data;
        if (eval) begin
            case (cfg_reg.reference_update_mode)
                mcr_pkg::MCR_REF_FIRST_OT: begin
                    if (first_pend_reg || refresh_pend_reg || (!ot_flag_reg && ot_flag_next)) begin
                        ref_wr = 3'h7;
                    end
                end
                mcr_pkg::MCR_REF_HOLD: begin
                    if (first_pend_reg || refresh_pend_reg) begin
                        ref_wr = 3'h7;
                    end
                end
                mcr_pkg::MCR_REF_SLOPE: begin
                    ref_wr = 3'h7;
                end
                mcr_pkg::MCR_REF_ZERO: begin
                    // a refresh here reloads nothing: the cells stay zero
                    ref_wr    = 3'h7;
                    ref_wdata = '0;
                end
                default: begin
                    ref_wr = 3'h0;
                end
            endcase
        end
    end

    mcr_ref_store u_ref_store (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .wr_en   (ref_wr),
        .wr_data (ref_wdata),
        .rd_data (ref_stored)
    );

    // ================================================================
    // outputs, all from flip-flops
    // ================================================================
    assign reg_rdata          = rdata_reg;
    assign outside_event_flag = ot_flag_reg;
    assign inside_event_flag  = wt_flag_reg;
    assign reference          = ref_stored;

endmodule

// ---- testbench/mcr_change_ctrl_sva.sv ----
`timescale 1ns/10ps
// ============================================================
// port checks for the change detector control
module mcr_change_ctrl_sva (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  ce,
    input wire mcr_pkg::mcr_reg_req_t reg_req,
    input wire logic [7:0]            reg_rdata,
    input wire mcr_pkg::mcr_sample_t  sample,
    input wire mcr_pkg::mcr_data_t    upper_threshold,
    input wire mcr_pkg::mcr_data_t    lower_threshold,
    input wire logic [2:0]            outside_axis_enable,
    input wire logic [2:0]            inside_axis_enable,
    input wire logic                  outside_event_flag,
    input wire logic                  inside_event_flag,
    input wire mcr_pkg::mcr_triplet_t reference
);
    logic               wr_hit, smp_hit, pend_reg, pend_next, first_reg, first_next, ocond, icond, ot_ev, it_ev;
    logic [7:0]         cfg_reg, cfg_next, rb_exp;
    logic [2:0]         out_ax, use_ax;
    logic signed [12:0] d;

    // shadow of config, pending refresh and first-sample mark; a set beats a retire
    always_comb begin
        wr_hit     = ce && reg_req.wr_en && reg_req.addr == mcr_pkg::MCR_CONFIG_B_ADDR;
        smp_hit    = ce && sample.valid;
        cfg_next   = wr_hit ? reg_req.wdata : cfg_reg;
        pend_next  = (wr_hit && reg_req.wdata[0]) || (pend_reg && !smp_hit);
        first_next = (wr_hit && reg_req.wdata[7] && !cfg_reg[7]) || (first_reg && !smp_hit);
    end

    always_ff @(posedge clk) begin
        cfg_reg   <= rst ? 8'h00 : cfg_next;
        pend_reg  <= rst ? 1'b0 : pend_next;
        first_reg <= rst ? 1'b0 : first_next;
    end

    // window test per channel; absolute mode compares against zero
    always_comb begin
        use_ax = cfg_reg[1] ? 3'h1 : 3'h7;  // magnitude input masks y and z
        for (int i = 0; i < 3; i++) begin
            d         = (i == 0 && cfg_reg[1]) ? $signed(sample.magnitude) : $signed(sample.axes[i]);
            d         = d - (cfg_reg[6:5] == 2'b11 ? 13'sh0000 : $signed(reference[i]));
            out_ax[i] = d > upper_threshold || d < lower_threshold;
        end
        ocond = |(out_ax & outside_axis_enable & use_ax);
        icond = cfg_reg[2] ? |(~out_ax & inside_axis_enable & use_ax)
                           : |(inside_axis_enable & use_ax) && !(|(out_ax & inside_axis_enable & use_ax));
        rb_exp = {cfg_reg[7:1], pend_reg};
        ot_ev  = ocond && smp_hit;
        it_ev  = icond && smp_hit;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // the first sample after enabling is left out: its comparison base is not yet settled
    sequence s_eval;
        smp_hit && cfg_reg[7] && !first_reg;
    endsequence

    property p_zero; smp_hit && cfg_reg[7] && cfg_reg[6:5] == 2'b11 |=> reference == '0; endproperty
    a_zero: assert property (p_zero) else $error("reference not zero");
    property p_slope; s_eval ##0 (cfg_reg[6:5] == 2'b10 && !cfg_reg[1]) |=> reference == $past(sample.axes); endproperty
    a_slope: assert property (p_slope) else $error("reference not last sample");
    property p_hold; s_eval ##0 (cfg_reg[6:5] == 2'b01 && !pend_reg) |=> $stable(reference); endproperty
    a_hold: assert property (p_hold) else $error("held reference moved");
    property p_reload;
        smp_hit && cfg_reg[7] && pend_reg && cfg_reg[6:5] != 2'b11 && !cfg_reg[1] |=> reference == $past(sample.axes);
    endproperty
    a_reload: assert property (p_reload) else $error("refresh did not reload");
    property p_readback;
        ce && reg_req.rd_en && reg_req.addr == mcr_pkg::MCR_CONFIG_B_ADDR |=> reg_rdata == $past(rb_exp);
    endproperty
    a_readback: assert property (p_readback) else $error("config readback wrong");
    property p_off; wr_hit && !reg_req.wdata[7] |=> ##1 (!outside_event_flag && !inside_event_flag); endproperty
    a_off: assert property (p_off) else $error("flags survive disable");
    property p_ot_clr; s_eval ##0 (cfg_reg[4] && !ocond) |=> !outside_event_flag; endproperty
    a_ot_clr: assert property (p_ot_clr) else $error("outside flag not cleared");
    property p_it_clr; s_eval ##0 (cfg_reg[3] && !icond) |=> !inside_event_flag; endproperty
    a_it_clr: assert property (p_it_clr) else $error("inside flag not cleared");
    property p_ot_rise; $rose(outside_event_flag) |-> $past(ot_ev); endproperty
    a_ot_rise: assert property (p_ot_rise) else $error("outside flag rose without cause");
    property p_it_rise; $rose(inside_event_flag) |-> $past(it_ev); endproperty
    a_it_rise: assert property (p_it_rise) else $error("inside flag rose without cause");
endmodule

// ---- testbench/mcr_host_model.sv ----
`timescale 1ns/10ps
// ============================================================
// host model: one byte access per call, taken at the next edge
module mcr_host_model (
    input  wire logic             clk,
    output mcr_pkg::mcr_reg_req_t reg_req
);
    logic mag_calc_enable = 1'b0;  // lives in another register, noted only

    initial reg_req = '0;

    // launch after an edge, hold through the taking edge, then drop
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        mag_calc_enable <= mag_calc_enable | (wr && v[1]);  // set along with magnitude input
        reg_req         <= '{wr, !wr, a, v};
        @(posedge clk);
        reg_req <= '0;
    endtask
endmodule

// ---- testbench/mcr_change_ctrl_bench.sv ----
`timescale 1ns/10ps
// ============================================================
// self-checking bench for the change detector control
module mcr_change_ctrl_bench;
    logic                  clk = 1'b0, rst = 1'b1, ce = 1'b1, smp_chk = 1'b0, rd_d = 1'b0, sv_d = 1'b0;
    mcr_pkg::mcr_reg_req_t reg_req;
    logic [7:0]            reg_rdata;
    mcr_pkg::mcr_sample_t  sample = '0;
    mcr_pkg::mcr_data_t    upper_threshold = 12'h064, lower_threshold = 12'hf9c;
    logic [2:0]            outside_axis_enable = 3'h0, inside_axis_enable = 3'h0;
    logic [7:0]            outside_debounce_threshold = 8'h00, inside_debounce_threshold = 8'h00;
    logic                  outside_event_flag, inside_event_flag;
    mcr_pkg::mcr_triplet_t reference, ta, tb;
    logic [31:0]           lfsr_reg = 32'h1b13;
    logic [7:0]            rd_q[$];
    logic [37:0]           smp_q[$];
    int                    failures = 0, cmp_count = 0;

    mcr_change_ctrl dut (.clk, .rst, .ce, .reg_req, .reg_rdata, .sample, .upper_threshold, .lower_threshold,
        .outside_axis_enable, .inside_axis_enable, .outside_debounce_threshold, .inside_debounce_threshold,
        .outside_event_flag, .inside_event_flag, .reference);
    mcr_host_model host (.clk, .reg_req);

    // ============================================================
    // clock, watchdog and helpers
    initial forever #5 clk = ~clk;

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    function automatic mcr_pkg::mcr_triplet_t trip(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        return {z, y, x};
    endfunction

    // any 12-bit value is a legal sample, so no range limit
    function automatic mcr_pkg::mcr_triplet_t rnd();
        mcr_pkg::mcr_triplet_t t;
        for (int i = 0; i < 3; i++) begin
            lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
            t[i]     = lfsr_reg[11:0];
        end
        return t;
    endfunction

    task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("Error reg_rdata expected %h seen %h", e, g);
        end
    endtask

    task automatic chk_smp(input logic [37:0] e, input logic [37:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("Error flags_and_reference expected %h seen %h", e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.access(1'b1, a, v);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask

    // one-cycle sample pulse; the expected outcome is noted as it is sent
    task automatic smp(input logic c, input mcr_pkg::mcr_triplet_t t, input logic [11:0] m, input logic eo,
                       input logic ei, input mcr_pkg::mcr_triplet_t er);
        @(posedge clk);
        sample  <= '{1'b1, t, m};
        smp_chk <= c;
        if (c)
            smp_q.push_back({eo, ei, er});
        @(posedge clk);
        sample.valid <= 1'b0;
    endtask

    task automatic so(input logic [11:0] x, input logic e);
        smp(1'b1, trip(x, 12'h000, 12'h000), 12'h000, e, 1'b0, '0);
    endtask

    task automatic si(input logic [11:0] x, input logic [11:0] y, input logic e);
        smp(1'b1, trip(x, y, 12'h000), 12'h000, 1'b0, e, '0);
    endtask

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // results land one edge after the request edge
    always @(posedge clk) begin
        if (rd_d)
            chk_rd(rd_q.size() ? rd_q.pop_front() : 8'hxx, reg_rdata);
        if (sv_d)
            chk_smp(smp_q.size() ? smp_q.pop_front() : 38'hx, {outside_event_flag, inside_event_flag, reference});
        rd_d <= reg_req.rd_en;
        sv_d <= sample.valid && smp_chk;
    end

    // ============================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(8'h30, 8'h00);
        wr(8'h31, 8'hff);
        rd(8'h31, 8'h00);
        rd(8'h30, 8'h00);
        done("registers");
        wr(8'h30, 8'ha0);
        ta = rnd();
        smp(1'b1, ta, 12'h000, 1'b0, 1'b0, ta);
        tb = rnd();
        smp(1'b1, tb, 12'h000, 1'b0, 1'b0, ta);
        wr(8'h30, 8'ha1);
        rd(8'h30, 8'ha1);
        tb = rnd();
        smp(1'b1, tb, 12'h000, 1'b0, 1'b0, tb);
        rd(8'h30, 8'ha0);
        wr(8'h30, 8'hc0);
        for (int i = 0; i < 4; i++) begin
            ta = rnd();
            smp(1'b1, ta, 12'h000, 1'b0, 1'b0, ta);
        end
        wr(8'h30, 8'he1);
        smp(1'b1, ta, 12'h000, 1'b0, 1'b0, '0);
        rd(8'h30, 8'he0);
        wr(8'h30, 8'h00);
        wr(8'h30, 8'h01);
        rd(8'h30, 8'h01);
        smp(1'b0, ta, 12'h000, 1'b0, 1'b0, '0);
        rd(8'h30, 8'h00);
        done("reference modes");
        outside_axis_enable <= 3'h1;
        wr(8'h30, 8'h80);
        tb = trip(12'h00a, 12'h000, 12'h000);
        ta = trip(12'h12c, 12'h000, 12'h000);
        smp(1'b1, tb, 12'h000, 1'b0, 1'b0, tb);
        smp(1'b1, ta, 12'h000, 1'b1, 1'b0, ta);
        smp(1'b1, ta, 12'h000, 1'b0, 1'b0, ta);
        outside_debounce_threshold <= 8'h02;
        wr(8'h30, 8'he0);
        so(12'h0c8, 1'b0);
        so(12'h0c8, 1'b1);
        so(12'h000, 1'b1);
        so(12'h000, 1'b1);
        so(12'h000, 1'b0);
        wr(8'h30, 8'hf0);
        so(12'h0c8, 1'b0);
        so(12'h0c8, 1'b1);
        so(12'h000, 1'b0);
        done("outside debounce");
        outside_axis_enable       <= 3'h0;
        inside_axis_enable        <= 3'h3;
        inside_debounce_threshold <= 8'h01;
        wr(8'h30, 8'he0);
        si(12'h000, 12'h1f4, 1'b0);
        si(12'h000, 12'h000, 1'b1);
        si(12'h000, 12'h1f4, 1'b1);
        si(12'h000, 12'h1f4, 1'b0);
        wr(8'h30, 8'hec);
        si(12'h000, 12'h1f4, 1'b1);
        si(12'h1f4, 12'h1f4, 1'b0);
        done("inside debounce");
        inside_axis_enable         <= 3'h0;
        outside_axis_enable        <= 3'h7;
        outside_debounce_threshold <= 8'h00;
        wr(8'h30, 8'he2);
        ta = trip(12'h1f4, 12'h1f4, 12'h1f4);
        smp(1'b1, ta, 12'h00a, 1'b0, 1'b0, '0);
        smp(1'b1, ta, 12'h12c, 1'b1, 1'b0, '0);
        wr(8'h30, 8'h00);
        rd(8'h30, 8'h00);
        done("magnitude");
        for (int n = 0; n < 10 && (rd_q.size() || smp_q.size()); n++)
            @(posedge clk);
        if (rd_q.size() || smp_q.size())
            failures++;
        tally_and_finish();
    end
endmodule

bind mcr_change_ctrl mcr_change_ctrl_sva u_sva (.clk, .rst, .ce, .reg_req, .reg_rdata, .sample, .upper_threshold,
    .lower_threshold, .outside_axis_enable, .inside_axis_enable, .outside_event_flag, .inside_event_flag, .reference);
